/* rtl/dma_chan_regs.vh */
// Register offsets, field positions and reset values of the DMA channel register block.
// Assumes inclusion by the register block only; definitions only.
`ifndef DMA_CHAN_REGS_VH
`define DMA_CHAN_REGS_VH

// ----------------------------------------
// Byte offsets
// ----------------------------------------
`define OFS_IRQ_RAW        8'h00
`define OFS_IRQ_STATUS     8'h04
`define OFS_IRQ_ENABLE     8'h08
`define OFS_IRQ_CLEAR      8'h0c
`define OFS_MISC           8'h44
`define OFS_RX_CFG_MAIN    8'h70
`define OFS_RX_CFG_AUX     8'h74
`define OFS_RX_FIFO_STATE  8'h78
`define OFS_RX_DBG_POP     8'h7c
`define OFS_RX_LINK        8'h80
`define OFS_RX_STATE       8'h84
`define OFS_RX_EOF_ADDR    8'h88
`define OFS_TX_CFG_MAIN    8'hd0
`define OFS_TX_CFG_AUX     8'hd4
`define OFS_TX_DBG_PUSH    8'hdc
`define OFS_TX_LINK        8'he0

// ----------------------------------------
// Interrupt bit positions
// ----------------------------------------
`define IRQ_RX_DONE        0
`define IRQ_RX_GOOD_END    1
`define IRQ_RX_ERR_END     2
`define IRQ_TX_DONE        3
`define IRQ_TX_END_FRAME   4
`define IRQ_RX_DESC_ERR    5
`define IRQ_TX_DESC_ERR    6
`define IRQ_RX_EXHAUSTED   7
`define IRQ_TX_CHAIN_DONE  8
`define IRQ_RX_FIFO_OVF    9
`define IRQ_RX_FIFO_UDF    10
`define IRQ_TX_FIFO_OVF    11
`define IRQ_TX_FIFO_UDF    12
`define IRQ_COUNT          13

// ----------------------------------------
// Field positions
// ----------------------------------------
`define MISC_BUS_RST       0
`define MISC_ARB_DIS       1
`define MISC_CLK_FORCE     2
`define CFG_CHAN_RST       0
`define CFG_LOOP_TEST      1
`define RXC_DESC_BURST     2
`define RXC_DATA_BURST     3
`define RXC_MEM2MEM        4
`define TXC_AUTO_WRBACK    2
`define TXC_END_MODE       3
`define TXC_DESC_BURST     4
`define TXC_DATA_BURST     5
`define AUX_OWNER_CHECK    0
`define LINK_ADDR_W        20
`define RXL_AUTO_RET       20
`define RXL_STOP           21
`define RXL_START          22
`define RXL_RESTART        23
`define RXL_IDLE           24
`define TXL_STOP           20
`define TXL_START          21
`define TXL_RESTART        22
`define TXL_IDLE           23
`define FIFO_CNT_W         6
`define POP_DATA_W         12
`define POP_BIT            12
`define PUSH_DATA_W        9
`define PUSH_BIT           9

// ----------------------------------------
// Reset values
// ----------------------------------------
`define RST_IRQ            13'h0000
`define RST_LINK_ADDR      20'h00000
`define RST_WORD           32'h0000_0000

`endif

/* rtl/dma_chan_regs.v */
// Register block of one receive/transmit channel pair of a descriptor-chain DMA engine.
// Assumes a classic Wishbone master on clk_i and a datapath on the same clock
// that reports events as one-cycle pulses and status as levels.
`timescale 1ns/10ps
`default_nettype none
`include "dma_chan_regs.vh"

module dma_chan_regs (
    // Clock and reset
    input  wire        clk_i,
    input  wire        rst_i,
    // Wishbone slave
    input  wire        cyc_i,
    input  wire        stb_i,
    input  wire        we_i,
    input  wire [7:0]  adr_i,
    input  wire [3:0]  sel_i,
    input  wire [31:0] dat_i,
    output reg  [31:0] dat_o,
    output reg         ack_o,
    // Receive datapath events
    input  wire        rx_last_data_i,
    input  wire        rx_owner_err_i,
    input  wire        rx_word_err_i,
    input  wire        rx_buf_full_i,
    input  wire        rx_unfinished_i,
    input  wire        rx_no_next_i,
    input  wire        rx_fifo_ovf_i,
    input  wire        rx_fifo_udf_i,
    input  wire        rx_eof_desc_done_i,
    // Transmit datapath events
    input  wire        tx_delivered_last_i,
    input  wire        tx_fetched_last_i,
    input  wire        tx_popped_last_i,
    input  wire        tx_owner_err_i,
    input  wire        tx_word_err_i,
    input  wire        tx_chain_sent_i,
    input  wire        tx_fifo_ovf_i,
    input  wire        tx_fifo_udf_i,
    // Datapath status
    input  wire        rx_fifo_full_i,
    input  wire        rx_fifo_empty_i,
    input  wire [5:0]  rx_fifo_byte_count_i,
    input  wire [31:0] rx_current_desc_addr_i,
    input  wire        rx_desc_fsm_idle_i,
    input  wire        tx_desc_fsm_idle_i,
    input  wire        rx_pop_valid_i,
    input  wire [11:0] rx_pop_data_i,
    // Global controls
    output wire        bus_master_reset_o,
    output wire        priority_arb_disable_o,
    output wire        register_clock_force_o,
    output wire        mem_to_mem_enable_o,
    // Receive controls
    output wire        rx_channel_reset_o,
    output wire        rx_desc_burst_enable_o,
    output wire        rx_data_burst_enable_o,
    output wire        rx_error_auto_return_o,
    output wire [19:0] rx_first_desc_addr_o,
    output reg         rx_chain_start_o,
    output reg         rx_chain_stop_o,
    output reg         rx_chain_restart_o,
    output reg         rx_fifo_debug_pop_o,
    // Transmit controls
    output wire        tx_channel_reset_o,
    output wire        tx_desc_burst_enable_o,
    output wire        tx_data_burst_enable_o,
    output wire        tx_auto_writeback_o,
    output wire [19:0] tx_first_desc_addr_o,
    output reg         tx_chain_start_o,
    output reg         tx_chain_stop_o,
    output reg         tx_chain_restart_o,
    output reg         tx_fifo_debug_push_o,
    output reg  [8:0]  tx_fifo_debug_word_o,
    // Interrupt
    output wire        irq_o
);

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    function [31:0] merge;
        input [31:0] old_v;
        input [31:0] new_v;
        input [3:0]  sel;
        integer      i;
        begin
            merge = old_v;
            for (i = 0; i < 4; i = i + 1) begin
                if (sel[i]) begin
                    merge[i*8 +: 8] = new_v[i*8 +: 8];
                end
            end
        end
    endfunction

    function [31:0] lanes;
        input [31:0] v;
        input [3:0]  sel;
        begin
            lanes = v & {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
        end
    endfunction

    // ----------------------------------------
    // Storage
    // ----------------------------------------
    reg  [12:0] irq_raw_r;
    reg  [12:0] irq_raw_nxt;
    reg  [12:0] irq_ena_r;
    reg  [31:0] misc_r;
    reg  [31:0] rx_cfg_r;
    reg  [31:0] rx_aux_r;
    reg  [31:0] tx_cfg_r;
    reg  [31:0] tx_aux_r;
    reg  [19:0] rx_link_addr_r;
    reg         rx_auto_ret_r;
    reg  [19:0] tx_link_addr_r;
    reg  [11:0] rx_pop_word_r;
    reg  [31:0] rx_eof_addr_r;

    wire        access   = cyc_i & stb_i & ~ack_o;
    wire        wr_acc   = access & we_i;
    wire [31:0] wr_bits  = lanes(dat_i, sel_i);
    wire [12:0] masked   = irq_raw_r & irq_ena_r;

    // Lane merges of the narrow fields; only the low bits are kept
    wire [31:0] ena_mrg  = merge({19'h00000, irq_ena_r}, dat_i, sel_i);
    wire [31:0] push_mrg = merge({23'h000000, tx_fifo_debug_word_o}, dat_i, sel_i);
    wire [31:0] rxl_mrg  = merge({12'h000, rx_link_addr_r}, dat_i, sel_i);
    wire [31:0] txl_mrg  = merge({12'h000, tx_link_addr_r}, dat_i, sel_i);

    assign irq_o                  = |masked;
    assign bus_master_reset_o     = misc_r[`MISC_BUS_RST];
    assign priority_arb_disable_o = misc_r[`MISC_ARB_DIS];
    assign register_clock_force_o = misc_r[`MISC_CLK_FORCE];
    assign rx_channel_reset_o     = rx_cfg_r[`CFG_CHAN_RST];
    assign tx_channel_reset_o     = tx_cfg_r[`CFG_CHAN_RST];
    assign rx_desc_burst_enable_o = rx_cfg_r[`RXC_DESC_BURST];
    assign rx_data_burst_enable_o = rx_cfg_r[`RXC_DATA_BURST];
    assign tx_desc_burst_enable_o = tx_cfg_r[`TXC_DESC_BURST];
    assign tx_data_burst_enable_o = tx_cfg_r[`TXC_DATA_BURST];
    assign mem_to_mem_enable_o    = rx_cfg_r[`RXC_MEM2MEM];
    assign tx_auto_writeback_o    = tx_cfg_r[`TXC_AUTO_WRBACK];
    assign rx_error_auto_return_o = rx_auto_ret_r;
    assign rx_first_desc_addr_o   = rx_link_addr_r;
    assign tx_first_desc_addr_o   = tx_link_addr_r;

    // ----------------------------------------
    // Interrupt sources
    // ----------------------------------------
    // Owner faults only count while checking is on; word faults always count
    wire rx_desc_err = (rx_owner_err_i & rx_aux_r[`AUX_OWNER_CHECK]) | rx_word_err_i;
    wire tx_desc_err = (tx_owner_err_i & tx_aux_r[`AUX_OWNER_CHECK]) | tx_word_err_i;
    wire tx_end_ev   = tx_cfg_r[`TXC_END_MODE] ? tx_popped_last_i
                                               : tx_fetched_last_i;
    wire rx_exhaust  = rx_buf_full_i & rx_unfinished_i & rx_no_next_i;

    reg  [12:0] irq_set;
    reg  [12:0] irq_clr;

    always @* begin
        irq_set                     = `RST_IRQ;
        irq_set[`IRQ_RX_DONE]       = rx_last_data_i;
        irq_set[`IRQ_RX_GOOD_END]   = rx_last_data_i;
        irq_set[`IRQ_TX_DONE]       = tx_delivered_last_i;
        irq_set[`IRQ_TX_END_FRAME]  = tx_end_ev;
        irq_set[`IRQ_RX_DESC_ERR]   = rx_desc_err;
        irq_set[`IRQ_TX_DESC_ERR]   = tx_desc_err;
        irq_set[`IRQ_RX_EXHAUSTED]  = rx_exhaust;
        irq_set[`IRQ_TX_CHAIN_DONE] = tx_chain_sent_i;
        irq_set[`IRQ_RX_FIFO_OVF]   = rx_fifo_ovf_i;
        irq_set[`IRQ_RX_FIFO_UDF]   = rx_fifo_udf_i;
        irq_set[`IRQ_TX_FIFO_OVF]   = tx_fifo_ovf_i;
        irq_set[`IRQ_TX_FIFO_UDF]   = tx_fifo_udf_i;
        irq_clr = `RST_IRQ;
        if (wr_acc && (adr_i == `OFS_IRQ_RAW || adr_i == `OFS_IRQ_CLEAR)) begin
            irq_clr = wr_bits[12:0];
        end
        // A new event beats a clear in the same cycle
        irq_raw_nxt = (irq_raw_r & ~irq_clr) | irq_set;
    end

    // ----------------------------------------
    // Register writes and strobes
    // ----------------------------------------
    always @(posedge clk_i) begin
        if (rst_i) begin
            irq_raw_r            <= `RST_IRQ;
            irq_ena_r            <= `RST_IRQ;
            misc_r               <= `RST_WORD;
            rx_cfg_r             <= `RST_WORD;
            rx_aux_r             <= `RST_WORD;
            tx_cfg_r             <= `RST_WORD;
            tx_aux_r             <= `RST_WORD;
            rx_link_addr_r       <= `RST_LINK_ADDR;
            rx_auto_ret_r        <= 1'b0;
            tx_link_addr_r       <= `RST_LINK_ADDR;
            rx_chain_start_o     <= 1'b0;
            rx_chain_stop_o      <= 1'b0;
            rx_chain_restart_o   <= 1'b0;
            tx_chain_start_o     <= 1'b0;
            tx_chain_stop_o      <= 1'b0;
            tx_chain_restart_o   <= 1'b0;
            rx_fifo_debug_pop_o  <= 1'b0;
            tx_fifo_debug_push_o <= 1'b0;
            tx_fifo_debug_word_o <= 9'h000;
        end else begin
            irq_raw_r            <= irq_raw_nxt;
            // Self-clearing bits live one cycle only and read back as 0
            rx_chain_start_o     <= 1'b0;
            rx_chain_stop_o      <= 1'b0;
            rx_chain_restart_o   <= 1'b0;
            tx_chain_start_o     <= 1'b0;
            tx_chain_stop_o      <= 1'b0;
            tx_chain_restart_o   <= 1'b0;
            rx_fifo_debug_pop_o  <= 1'b0;
            tx_fifo_debug_push_o <= 1'b0;
            if (wr_acc) begin
                case (adr_i)
                    `OFS_IRQ_ENABLE: begin
                        irq_ena_r <= ena_mrg[12:0];
                    end
                    `OFS_MISC: begin
                        misc_r <= merge(misc_r, dat_i, sel_i) & 32'h0000_0007;
                    end
                    `OFS_RX_CFG_MAIN: begin
                        rx_cfg_r <= merge(rx_cfg_r, dat_i, sel_i) & 32'h0000_001f;
                    end
                    `OFS_RX_CFG_AUX: begin
                        rx_aux_r <= merge(rx_aux_r, dat_i, sel_i) & 32'h0000_0001;
                    end
                    `OFS_TX_CFG_MAIN: begin
                        tx_cfg_r <= merge(tx_cfg_r, dat_i, sel_i) & 32'h0000_003f;
                    end
                    `OFS_TX_CFG_AUX: begin
                        tx_aux_r <= merge(tx_aux_r, dat_i, sel_i) & 32'h0000_0001;
                    end
                    `OFS_RX_DBG_POP: begin
                        rx_fifo_debug_pop_o <= wr_bits[`POP_BIT];
                    end
                    `OFS_TX_DBG_PUSH: begin
                        tx_fifo_debug_word_o <= push_mrg[8:0];
                        tx_fifo_debug_push_o <= wr_bits[`PUSH_BIT];
                    end
                    `OFS_RX_LINK: begin
                        rx_link_addr_r <= rxl_mrg[19:0];
                        if (sel_i[2]) begin
                            rx_auto_ret_r <= dat_i[`RXL_AUTO_RET];
                        end
                        rx_chain_stop_o    <= wr_bits[`RXL_STOP];
                        rx_chain_start_o   <= wr_bits[`RXL_START];
                        rx_chain_restart_o <= wr_bits[`RXL_RESTART];
                    end
                    `OFS_TX_LINK: begin
                        tx_link_addr_r <= txl_mrg[19:0];
                        tx_chain_stop_o    <= wr_bits[`TXL_STOP];
                        tx_chain_start_o   <= wr_bits[`TXL_START];
                        tx_chain_restart_o <= wr_bits[`TXL_RESTART];
                    end
                    default: begin
                    end
                endcase
            end
        end
    end

    // ----------------------------------------
    // Captured datapath words
    // ----------------------------------------
    // Channel reset also drops the stale debug word with the FIFO pointers
    always @(posedge clk_i) begin
        if (rst_i) begin
            rx_pop_word_r <= 12'h000;
            rx_eof_addr_r <= `RST_WORD;
        end else begin
            if (rx_cfg_r[`CFG_CHAN_RST]) begin
                rx_pop_word_r <= 12'h000;
            end else if (rx_pop_valid_i) begin
                rx_pop_word_r <= rx_pop_data_i;
            end
            if (rx_eof_desc_done_i) begin
                rx_eof_addr_r <= rx_current_desc_addr_i;
            end
        end
    end

    // ----------------------------------------
    // Read mux and acknowledge
    // ----------------------------------------
    reg [31:0] rd_nxt;

    always @* begin
        rd_nxt = `RST_WORD;
        case (adr_i)
            `OFS_IRQ_RAW:       rd_nxt = {19'h00000, irq_raw_r};
            `OFS_IRQ_STATUS:    rd_nxt = {19'h00000, masked};
            `OFS_IRQ_ENABLE:    rd_nxt = {19'h00000, irq_ena_r};
            `OFS_MISC:          rd_nxt = misc_r;
            `OFS_RX_CFG_MAIN:   rd_nxt = rx_cfg_r;
            `OFS_RX_CFG_AUX:    rd_nxt = rx_aux_r;
            `OFS_RX_FIFO_STATE: rd_nxt = {24'h000000, rx_fifo_byte_count_i,
                                          rx_fifo_empty_i, rx_fifo_full_i};
            `OFS_RX_DBG_POP:    rd_nxt = {20'h00000, rx_pop_word_r};
            `OFS_RX_LINK:       rd_nxt = {7'h00, rx_desc_fsm_idle_i, 3'h0,
                                          rx_auto_ret_r, rx_link_addr_r};
            `OFS_RX_STATE:      rd_nxt = {12'h000, rx_current_desc_addr_i[19:0]};
            `OFS_RX_EOF_ADDR:   rd_nxt = rx_eof_addr_r;
            `OFS_TX_CFG_MAIN:   rd_nxt = tx_cfg_r;
            `OFS_TX_CFG_AUX:    rd_nxt = tx_aux_r;
            `OFS_TX_DBG_PUSH:   rd_nxt = {23'h000000, tx_fifo_debug_word_o};
            `OFS_TX_LINK:       rd_nxt = {8'h00, tx_desc_fsm_idle_i, 3'h0,
                                          tx_link_addr_r};
            default:            rd_nxt = `RST_WORD;
        endcase
    end

    // Every access is answered in one cycle; unmapped reads return zero
    always @(posedge clk_i) begin
        if (rst_i) begin
            ack_o <= 1'b0;
            dat_o <= `RST_WORD;
        end else begin
            ack_o <= access;
            if (access && !we_i) begin
                dat_o <= rd_nxt;
            end
        end
    end

endmodule // dma_chan_regs

`default_nettype wire

/* sim/dma_chan_regs_chk.sv */
// Concurrent checks on the ports of the DMA channel register block.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/10ps
`default_nettype none
module dma_chan_regs_chk (
    // Clock, reset and bus
    input wire logic        clk_i,
    input wire logic        rst_i,
    input wire logic        cyc_i,
    input wire logic        stb_i,
    input wire logic        we_i,
    input wire logic [7:0]  adr_i,
    input wire logic [3:0]  sel_i,
    input wire logic [31:0] dat_i,
    input wire logic        ack_o,
    // Watched outputs
    input wire logic        rx_chain_start_o,
    input wire logic        rx_fifo_debug_pop_o,
    input wire logic        tx_fifo_debug_push_o,
    input wire logic        bus_master_reset_o,
    input wire logic        rx_channel_reset_o,
    input wire logic        irq_o
);
    // Held request after ack is not taken again
    wire wr = cyc_i && stb_i && we_i && !ack_o;
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);
    start_pulse_a: assert property (
        wr && adr_i == 8'h80 && sel_i[2] && dat_i[22] |=> rx_chain_start_o ##1 !rx_chain_start_o)
        else $error("receive start is not a single pulse");
    start_cause_a: assert property (
        rx_chain_start_o |-> $past(wr && adr_i == 8'h80 && sel_i[2] && dat_i[22]))
        else $error("receive start without a write");
    pop_cause_a: assert property (
        rx_fifo_debug_pop_o |-> $past(wr && adr_i == 8'h7c && sel_i[1] && dat_i[12]))
        else $error("debug pop without a write");
    push_pulse_a: assert property (
        wr && adr_i == 8'hdc && sel_i[1] && dat_i[9] |=> tx_fifo_debug_push_o)
        else $error("debug push missing");
    bus_rst_a: assert property (
        !$stable(bus_master_reset_o) |-> $past(wr && adr_i == 8'h44 && sel_i[0]))
        else $error("bus master reset changed without a write");
    rx_rst_a: assert property (
        !$stable(rx_channel_reset_o) |-> $past(wr && adr_i == 8'h70 && sel_i[0]))
        else $error("receive reset changed without a write");
    irq_mask_a: assert property (
        wr && adr_i == 8'h08 && sel_i == 4'hf && dat_i[12:0] == 13'h0 |=> !irq_o)
        else $error("interrupt high with all sources disabled");
    irq_sticky_a: assert property (
        $fell(irq_o) |-> $past(wr))
        else $error("interrupt dropped without a write");
    cover property (rx_chain_start_o);
    cover property ($fell(irq_o));
    cover property (tx_fifo_debug_push_o);
endmodule // dma_chan_regs_chk
bind dma_chan_regs dma_chan_regs_chk i_chk (
    .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
    .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .ack_o(ack_o),
    .rx_chain_start_o(rx_chain_start_o), .rx_fifo_debug_pop_o(rx_fifo_debug_pop_o),
    .tx_fifo_debug_push_o(tx_fifo_debug_push_o), .bus_master_reset_o(bus_master_reset_o),
    .rx_channel_reset_o(rx_channel_reset_o), .irq_o(irq_o));
`default_nettype wire

/* sim/dma_dp_model.sv */
// Datapath stand-in: turns bench requests into event and level inputs.
// Assumes requests change right after a rising edge of clk_i.
`timescale 1ns/10ps
`default_nettype none
module dma_dp_model (
    // Clock and requests
    input  wire logic        clk_i,
    input  wire logic [15:0] req_i,
    // Events towards the block
    output var  logic [15:0] ev_o
);
    // Registered, so events land a cycle late as from a real datapath
    always @(posedge clk_i) begin
        ev_o <= req_i;
    end
endmodule // dma_dp_model
`default_nettype wire

/* sim/dma_chan_regs_bench.sv */
// Self-checking bench for the DMA channel register block.
// Assumes the datapath model dma_dp_model and the bound checker.
`timescale 1ns/10ps
`default_nettype none
module dma_chan_regs_bench;
    logic        clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0;
    logic        full = 0, emp = 0, ridle = 0, tidle = 0;
    logic [7:0]  adr = 0, st;
    logic [15:0] ev = 0;
    logic [11:0] pd = 0;
    logic [3:0]  sel = 4'hf;
    logic [5:0]  cnt = 0;
    logic [31:0] dat = 0, q, cur = 0, ena;
    logic [7:0]  ofs [14] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h44, 8'h70, 8'h74, 8'h78,
                              8'h7c, 8'h80, 8'h84, 8'h88, 8'hd0, 8'he0};
    int          errors = 0, n_compared = 0, raw = 0;
    wire  [15:0] e;
    wire  [31:0] dout;
    wire  [19:0] ra, ta;
    wire  [11:0] lv;
    wire  [8:0]  pw;
    wire  [7:0]  so;
    wire         ack, irq;

    dma_dp_model i_dp (.clk_i(clk_i), .req_i(ev), .ev_o(e));
    dma_chan_regs i_dut (
        .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr),
        .sel_i(sel), .dat_i(dat), .dat_o(dout), .ack_o(ack),
        .rx_last_data_i(e[0]), .rx_owner_err_i(e[1]), .rx_word_err_i(e[2]),
        .rx_fifo_ovf_i(e[3]), .rx_fifo_udf_i(e[4]), .tx_delivered_last_i(e[5]),
        .tx_fetched_last_i(e[6]), .tx_popped_last_i(e[7]), .tx_owner_err_i(e[8]),
        .tx_word_err_i(e[9]), .tx_chain_sent_i(e[10]), .tx_fifo_ovf_i(e[11]),
        .tx_fifo_udf_i(e[12]), .rx_buf_full_i(e[13]), .rx_unfinished_i(e[13]),
        .rx_no_next_i(e[13]), .rx_eof_desc_done_i(e[14]), .rx_pop_valid_i(e[15]),
        .rx_pop_data_i(pd), .rx_fifo_full_i(full), .rx_fifo_empty_i(emp),
        .rx_fifo_byte_count_i(cnt), .rx_current_desc_addr_i(cur),
        .rx_desc_fsm_idle_i(ridle), .tx_desc_fsm_idle_i(tidle),
        .bus_master_reset_o(lv[11]), .priority_arb_disable_o(lv[10]),
        .register_clock_force_o(lv[9]), .mem_to_mem_enable_o(lv[8]),
        .rx_channel_reset_o(lv[7]), .rx_desc_burst_enable_o(lv[6]),
        .rx_data_burst_enable_o(lv[5]), .rx_error_auto_return_o(lv[4]),
        .tx_channel_reset_o(lv[3]), .tx_desc_burst_enable_o(lv[2]),
        .tx_data_burst_enable_o(lv[1]), .tx_auto_writeback_o(lv[0]),
        .rx_first_desc_addr_o(ra), .tx_first_desc_addr_o(ta),
        .rx_chain_restart_o(so[7]), .rx_chain_start_o(so[6]), .rx_chain_stop_o(so[5]),
        .rx_fifo_debug_pop_o(so[4]), .tx_chain_restart_o(so[3]),
        .tx_chain_start_o(so[2]), .tx_chain_stop_o(so[1]),
        .tx_fifo_debug_push_o(so[0]), .tx_fifo_debug_word_o(pw), .irq_o(irq));

    initial forever #5 clk_i = ~clk_i;

    task automatic chk(input logic [31:0] g, input logic [31:0] x);
        n_compared++;
        if (g !== x) begin
            errors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, x);
        end
    endtask

    // Ack, read data and strobes taken at the rising edge that samples ack high
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k;
        k = 0;
        @(posedge clk_i);
        {cyc, stb, we, adr, dat} <= {2'b11, w, a, d};
        do begin
            @(posedge clk_i);
            k++;
        end while (ack !== 1'b1 && k < 20);
        q = dout;
        st = so;
        if (k >= 20) errors++;
        {cyc, stb} <= 2'b00;
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] x);
        bus(0, a, 0);
        chk(q, x);
    endtask

    task automatic pulse(input int i);
        @(posedge clk_i);
        ev <= 16'h1 << i;
        @(posedge clk_i);
        ev <= 16'h0;
    endtask

    // Raw flags each event should set; p selects owner check and end-flag mode
    function automatic int fx(input int i, input int p);
        case (i)
            0: return 13'h3;
            1: return p ? 13'h20 : 13'h0;
            2: return 13'h20;
            3: return 13'h200;
            4: return 13'h400;
            5: return 13'h8;
            6: return p ? 13'h0 : 13'h10;
            7: return p ? 13'h10 : 13'h0;
            8: return p ? 13'h40 : 13'h0;
            9: return 13'h40;
            10: return 13'h100;
            11: return 13'h800;
            12: return 13'h1000;
            13: return 13'h80;
            default: return 13'h0;
        endcase
    endfunction

    task automatic print_verdict();
        $display("errors=%0d compared=%0d", errors, n_compared);
        if (errors == 0 && n_compared > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    initial begin
        #200_000;
        errors++;
        print_verdict();
    end

    initial begin
        void'($urandom(67));
        repeat (12) @(posedge clk_i);
        rst_i <= 0;
        foreach (ofs[j]) rd(ofs[j], 0);
        for (int p = 0; p < 2; p++) begin
            ena = $urandom & 32'h1fff;
            cur <= $urandom;
            bus(1, 8'h08, ena);
            bus(1, 8'h74, p);
            bus(1, 8'hd4, p);
            bus(1, 8'hd0, p << 3);
            rd(8'h08, ena);
            for (int i = 0; i < 15; i++) begin
                pulse(i);
                raw |= fx(i, p);
                rd(8'h00, raw);
                rd(8'h04, raw & ena);
                chk(irq, |(raw & ena));
                if (i % 5 == 4) begin
                    bus(1, p ? 8'h0c : 8'h00, raw);
                    raw = 0;
                end
            end
            rd(8'h88, cur);
            rd(8'h84, cur & 32'hfffff);
        end
        pulse(0);
        bus(1, 8'h08, 0);
        chk(irq, 0);
        rd(8'h00, 32'h3);
        bus(1, 8'h44, 32'h7);
        bus(1, 8'h70, 32'h1e);
        bus(1, 8'hd0, 32'h3d);
        bus(1, 8'h80, 32'h1abcde);
        bus(1, 8'he0, 32'h54321);
        chk(lv, 12'hf7f);
        chk(ra, 20'habcde);
        chk(ta, 20'h54321);
        rd(8'h44, 32'h7);
        bus(1, 8'h44, 0);
        chk(lv[11], 0);
        ridle <= 1;
        tidle <= 1;
        rd(8'h80, 32'h11abcde);
        rd(8'he0, 32'h854321);
        for (int j = 0; j < 3; j++) begin
            bus(1, 8'h80, 32'h1 << (21 + j));
            chk(st, 8'h20 << j);
            bus(1, 8'he0, 32'h1 << (20 + j));
            chk(st, 8'h2 << j);
        end
        // Only lane 2 selected: start fires, unselected address lanes stay
        sel <= 4'h4;
        bus(1, 8'h80, 32'h004f_ffff);
        chk({st, ra}, {8'h40, 20'hf0000});
        sel <= 4'hf;
        pd <= 12'($urandom);
        pulse(15);
        rd(8'h7c, pd);
        bus(1, 8'h7c, 32'h1000);
        chk(st, 8'h10);
        bus(1, 8'hdc, {22'h0, 1'b1, pd[8:0]});
        chk({st, pw}, {8'h1, pd[8:0]});
        bus(1, 8'h70, 32'h1);
        rd(8'h7c, 0);
        {full, emp, cnt} <= 8'($urandom);
        @(posedge clk_i);
        rd(8'h78, {24'h0, cnt, emp, full});
        bus(1, 8'h40, 32'hffff_ffff);
        rd(8'h40, 0);
        print_verdict();
    end
endmodule // dma_chan_regs_bench
`default_nettype wire
